// ===== verilog/safe_cutoff_pkg.sv
// constants, register map and carrier types of the safe cutoff controller
// assumes a 20 MHz core clock and a 32-bit Avalon-MM register port
package safe_cutoff_pkg;

    // ------------
    // timing
    // ------------
    localparam int CLK_HZ          = 20000000;
    localparam int CLK_PER_US      = CLK_HZ / 1000000;
    // off pulses up to this length are rejected
    localparam int GLITCH_US       = 500;
    localparam int GLITCH_CYC      = GLITCH_US * CLK_PER_US;
    // longest delay from both channels off to power removed
    localparam int CUTOFF_MAX_US   = 8000;
    localparam int CUTOFF_MAX_CYC  = CUTOFF_MAX_US * CLK_PER_US;
    // channel disagreement time before the mismatch alarm
    localparam int MISMATCH_S      = 10;
    localparam int MISMATCH_CYC    = MISMATCH_S * CLK_HZ;
    localparam int GLITCH_W        = 14;
    localparam int MISMATCH_W      = 28;

    // ------------
    // register map (byte addresses)
    // ------------
    localparam logic [4:0] ADDR_CMD         = 5'h00;
    localparam logic [4:0] ADDR_CTRL        = 5'h04;
    localparam logic [4:0] ADDR_BRAKE_DELAY = 5'h08;
    localparam logic [4:0] ADDR_MONITOR     = 5'h0c;
    localparam logic [4:0] ADDR_IRQ_STATUS  = 5'h10;
    localparam logic [4:0] ADDR_IRQ_MASK    = 5'h14;

    // ctrl fields
    localparam int CTRL_MOTION_BIT  = 0;
    localparam int CTRL_CLEAR_BIT   = 1;

    // monitor fields
    localparam int MON_CUTOFF_BIT   = 0;
    localparam int MON_READY_BIT    = 1;
    localparam int MON_WARN_BIT     = 2;
    localparam int MON_ALARM_BIT    = 3;
    localparam int MON_FEEDBACK_BIT = 4;
    localparam int MON_CHAN_LSB     = 5;
    localparam int MON_STATE_LSB    = 8;

    // interrupt events
    localparam int IRQ_W            = 3;
    localparam int IRQ_CUTOFF_BIT   = 0;
    localparam int IRQ_WARN_BIT     = 1;
    localparam int IRQ_ALARM_BIT    = 2;

    // reset values
    localparam logic [15:0] BRAKE_DELAY_RST = 16'h0000;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    // ------------
    // host command codes
    // ------------
    localparam logic [7:0] CMD_ENERGIZE    = 8'h31;
    localparam logic [7:0] CMD_DEENERGIZE  = 8'h32;

    // ------------
    // types
    // ------------
    typedef enum logic [1:0] {
        ST_BLOCKED   = 2'b00,
        ST_ENERGIZED = 2'b01,
        ST_STOPPING  = 2'b11,
        ST_CUTOFF    = 2'b10
    } drive_state_t;

    // one bit per safety channel, high means current flows (on)
    typedef struct packed {
        logic b;
        logic a;
    } chan_pair_t;

endpackage

// ===== verilog/safe_torque_cutoff_ctrl.sv
// safe power cutoff sequencer with Avalon-MM control and status registers
// assumes standalone mode and main power level are plain synchronous levels
//
// Notes on behaviour
// - either channel off enters cutoff state
// - each channel gates power stage separately
// - input high means current flows, on
// - off pulses up to 0.5 ms ignored; that channel's gate enable still drops for the pulse
// - both off removes power within 8 ms
// - both on after de-energize leaves cutoff
// - energize during cutoff needs fresh de-energize
// - main power off needs de-energize to leave
// - cutoff flag set in monitor word
// - cutoff during motion raises command warning; raised on any cutoff from energized, motion bit unused
// - channels disagree 10 s raises alarm
// - standalone resume needs mode exit, re-entry
// - energize ignored, ready off during cutoff
// - ready only when both on and blocked
// - cutoff drops brake release, no delay
// - feedback on within 8 ms, both off
//
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps

module safe_torque_cutoff_ctrl
    import safe_cutoff_pkg::*;
#(
    parameter int GLITCH_CYCLES   = GLITCH_CYC,
    parameter int MISMATCH_CYCLES = MISMATCH_CYC
) (
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    // safety channels, high while current flows
    input  wire logic        i_safety_off_request_a,
    input  wire logic        i_safety_off_request_b,
    // drive conditions
    input  wire logic        i_main_power_on,
    input  wire logic        i_standalone_mode,
    // avalon-mm slave
    input  wire logic [4:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    // power stage and drive outputs
    output logic             o_gate_enable_a,
    output logic             o_gate_enable_b,
    output logic             o_drive_ready,
    output logic             o_brake_release_output,
    output logic             o_cutoff_feedback_output,
    output logic             o_irq
);

    // ------------
    // declarations
    // ------------
    chan_pair_t            raw;
    chan_pair_t            sync1;
    chan_pair_t            chan_on;
    logic [GLITCH_W-1:0]   glitch_cnt [2];
    logic [MISMATCH_W-1:0] mismatch_cnt;
    drive_state_t          state;
    drive_state_t          next_state;
    logic [15:0]           brake_delay_setting;
    logic [15:0]           stop_cnt;
    logic                  motion_busy;
    logic                  deen_ok;
    logic                  stand_hold;
    logic                  cmd_warning;
    logic                  channel_mismatch_alarm;
    logic [IRQ_W-1:0]      irq_status;
    logic [IRQ_W-1:0]      irq_mask;
    logic                  ack;

    // ------------
    // bus decode
    // ------------
    wire       req        = i_avs_read | i_avs_write;
    wire       wr_now     = i_avs_write & ack;
    wire       wr_cmd     = wr_now & (i_avs_address == ADDR_CMD);
    wire       wr_ctrl    = wr_now & (i_avs_address == ADDR_CTRL);
    wire       wr_bdelay  = wr_now & (i_avs_address == ADDR_BRAKE_DELAY);
    wire       wr_istat   = wr_now & (i_avs_address == ADDR_IRQ_STATUS);
    wire       wr_imask   = wr_now & (i_avs_address == ADDR_IRQ_MASK);
    wire [7:0] cmd_code   = i_avs_writedata[7:0];
    wire       cmd_on     = wr_cmd & (cmd_code == CMD_ENERGIZE);
    wire       cmd_off    = wr_cmd & (cmd_code == CMD_DEENERGIZE);
    wire       alarm_clr  = wr_ctrl & i_avs_writedata[CTRL_CLEAR_BIT];

    // ------------
    // channel conditions
    // ------------
    wire both_on    = chan_on.a & chan_on.b;
    wire both_off   = ~chan_on.a & ~chan_on.b;
    wire any_off    = ~both_on;
    wire is_cutoff  = (state == ST_CUTOFF);
    wire powered    = (state == ST_ENERGIZED) | (state == ST_STOPPING);
    wire enter_cut  = any_off & ~is_cutoff;
    wire stop_done  = (stop_cnt == brake_delay_setting);
    wire mm_full    = (mismatch_cnt ==
                       MISMATCH_W'(MISMATCH_CYCLES));

    // leaving cutoff: host path or standalone mode re-entry
    wire release_ok = both_on &
                      (i_standalone_mode ? ~stand_hold
                                         : deen_ok);

    // ------------
    // interrupt events
    // ------------
    logic [IRQ_W-1:0] irq_event;
    always_comb begin
        irq_event                 = '0;
        irq_event[IRQ_CUTOFF_BIT] = enter_cut;
        irq_event[IRQ_WARN_BIT]   = enter_cut & (state == ST_ENERGIZED);
        irq_event[IRQ_ALARM_BIT]  = mm_full & ~channel_mismatch_alarm;
    end

    // ------------
    // input synchronisers and off-pulse filter
    // ------------
    assign raw.a = i_safety_off_request_a;
    assign raw.b = i_safety_off_request_b;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1 <= '0;
        end else begin
            sync1 <= raw;
        end
    end

    chan_pair_t sync2;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sync2 <= '0;
        end else begin
            sync2 <= sync1;
        end
    end

    // a channel counts as off only after the off level outlasts the
    // rejection window; any on sample restores it at once
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_filter
            always_ff @(posedge i_core_clk or posedge i_rst) begin
                if (i_rst) begin
                    glitch_cnt[ch] <= '0;
                    chan_on[ch]    <= 1'b0;
                end else if (sync2[ch]) begin
                    glitch_cnt[ch] <= '0;
                    chan_on[ch]    <= 1'b1;
                end else if (glitch_cnt[ch] ==
                             GLITCH_W'(GLITCH_CYCLES)) begin
                    chan_on[ch]    <= 1'b0;
                end else begin
                    glitch_cnt[ch] <= glitch_cnt[ch] + 1'b1;
                end
            end
        end
    endgenerate

    // ------------
    // channel mismatch supervision
    // ------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            mismatch_cnt <= '0;
        end else if (chan_on.a == chan_on.b) begin
            mismatch_cnt <= '0;
        end else if (!mm_full) begin
            mismatch_cnt <= mismatch_cnt + 1'b1;
        end
    end

    // set wins over clear
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            channel_mismatch_alarm <= 1'b0;
        end else if (mm_full) begin
            channel_mismatch_alarm <= 1'b1;
        end else if (alarm_clr) begin
            channel_mismatch_alarm <= 1'b0;
        end
    end

    // ------------
    // command warning
    // ------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cmd_warning <= 1'b0;
        end else if (irq_event[IRQ_WARN_BIT]) begin
            cmd_warning <= 1'b1;
        end else if (alarm_clr) begin
            cmd_warning <= 1'b0;
        end
    end

    // ------------
    // drive state machine
    // ------------
    always_comb begin
        next_state = state;
        case (state)
            ST_BLOCKED: begin
                if (any_off) begin
                    next_state = ST_CUTOFF;
                end else if (cmd_on && i_main_power_on) begin
                    next_state = ST_ENERGIZED;
                end
            end
            ST_ENERGIZED: begin
                if (any_off) begin
                    next_state = ST_CUTOFF;
                end else if (cmd_off) begin
                    next_state = ST_STOPPING;
                end
            end
            ST_STOPPING: begin
                if (any_off) begin
                    next_state = ST_CUTOFF;
                end else if (stop_done) begin
                    next_state = ST_BLOCKED;
                end
            end
            ST_CUTOFF: begin
                // energize is never taken here
                if (release_ok) begin
                    next_state = ST_BLOCKED;
                end
            end
            default: begin
                next_state = ST_CUTOFF;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_CUTOFF;
        end else begin
            state <= next_state;
        end
    end

    // brake-to-power-off delay during a normal de-energize
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            stop_cnt <= '0;
        end else if (state != ST_STOPPING) begin
            stop_cnt <= '0;
        end else if (!stop_done) begin
            stop_cnt <= stop_cnt + 1'b1;
        end
    end

    // ------------
    // release qualifiers
    // ------------
    // deen_ok: a de-energize has been seen that permits leaving cutoff
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            deen_ok <= 1'b0;
        end else if (enter_cut) begin
            // entry from an idle drive counts as already de-energized
            deen_ok <= (state == ST_BLOCKED);
        end else if (is_cutoff) begin
            if (cmd_off) begin
                deen_ok <= 1'b1;
            end else if (cmd_on) begin
                deen_ok <= 1'b0;
            end else if (!i_main_power_on && !both_on) begin
                deen_ok <= 1'b0;
            end
        end
    end

    // stand_hold: standalone function interrupted, mode must be left
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            stand_hold <= 1'b0;
        end else if (enter_cut && i_standalone_mode && powered) begin
            stand_hold <= 1'b1;
        end else if (!i_standalone_mode) begin
            stand_hold <= 1'b0;
        end
    end

    // ------------
    // power stage and drive outputs
    // ------------
    // each gate follows its own channel as well as the state
    assign o_gate_enable_a = powered & chan_on.a & sync2.a;
    assign o_gate_enable_b = powered & chan_on.b & sync2.b;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_drive_ready            <= 1'b0;
            o_brake_release_output   <= 1'b0;
            o_cutoff_feedback_output <= 1'b0;
        end else begin
            o_drive_ready <= (next_state == ST_BLOCKED)
                             & both_on;
            o_brake_release_output <=
                (next_state == ST_ENERGIZED);
            o_cutoff_feedback_output <= both_off;
        end
    end

    // ------------
    // software registers
    // ------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            motion_busy         <= 1'b0;
            brake_delay_setting <= BRAKE_DELAY_RST;
            irq_mask            <= IRQ_MASK_RST;
        end else begin
            if (wr_ctrl) begin
                motion_busy <= i_avs_writedata[CTRL_MOTION_BIT];
            end
            if (wr_bdelay) begin
                brake_delay_setting <= i_avs_writedata[15:0];
            end
            if (wr_imask) begin
                irq_mask <= i_avs_writedata[IRQ_W-1:0];
            end
        end
    end

    // sticky events, write one to clear, set wins
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_status <= '0;
        end else begin
            irq_status <= irq_event |
                (irq_status &
                 ~(wr_istat ? i_avs_writedata[IRQ_W-1:0] : '0));
        end
    end

    assign o_irq = |(irq_status & irq_mask);

    // ------------
    // command io monitor word
    // ------------
    logic [31:0] monitor_word;
    always_comb begin
        monitor_word                   = '0;
        monitor_word[MON_CUTOFF_BIT]   = is_cutoff;
        monitor_word[MON_READY_BIT]    = o_drive_ready;
        monitor_word[MON_WARN_BIT]     = cmd_warning;
        monitor_word[MON_ALARM_BIT]    = channel_mismatch_alarm;
        monitor_word[MON_FEEDBACK_BIT] = o_cutoff_feedback_output;
        monitor_word[MON_CHAN_LSB+:2]  = chan_on;
        monitor_word[MON_STATE_LSB+:2] = state;
    end

    // ------------
    // read mux and bus handshake
    // ------------
    logic [31:0] rd_mux;
    always_comb begin
        case (i_avs_address)
            ADDR_CTRL:        rd_mux = {31'h0, motion_busy};
            ADDR_BRAKE_DELAY: rd_mux = {16'h0, brake_delay_setting};
            ADDR_MONITOR:     rd_mux = monitor_word;
            ADDR_IRQ_STATUS:  rd_mux = {29'h0, irq_status};
            ADDR_IRQ_MASK:    rd_mux = {29'h0, irq_mask};
            default:          rd_mux = 32'h0;
        endcase
    end

    // every access waits exactly one cycle
    assign o_avs_waitrequest = req & ~ack;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ack            <= 1'b0;
            o_avs_readdata <= 32'h0;
        end else begin
            ack <= req & ~ack;
            if (i_avs_read && !ack) begin
                o_avs_readdata <= rd_mux;
            end
        end
    end

endmodule

// ===== test/safe_cutoff_chk.sv
// checker: cutoff, feedback, ready, brake and bus answer timing
// assumes a bind to safe_torque_cutoff_ctrl with its count parameters
`timescale 1ns/1ps

module safe_cutoff_chk #(
    parameter int GLITCH_CYCLES   = 20,
    parameter int MISMATCH_CYCLES = 100
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // watched inputs
    input wire logic i_safety_off_request_a,
    input wire logic i_safety_off_request_b,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    // watched outputs
    input wire logic o_avs_waitrequest,
    input wire logic o_gate_enable_a,
    input wire logic o_gate_enable_b,
    input wire logic o_drive_ready,
    input wire logic o_brake_release_output,
    input wire logic o_cutoff_feedback_output
);
    // ------------
    // run lengths of the channel levels
    // ------------
    int lo_a;
    int lo_b;
    int hi_any;
    int up_cnt;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            lo_a   <= 0;
            lo_b   <= 0;
            hi_any <= 0;
            up_cnt <= 0;
        end else begin
            lo_a   <= i_safety_off_request_a ? 0 : lo_a + 1;
            lo_b   <= i_safety_off_request_b ? 0 : lo_b + 1;
            hi_any <= (i_safety_off_request_a | i_safety_off_request_b) ?
                      hi_any + 1 : 0;
            up_cnt <= (up_cnt < 15) ? up_cnt + 1 : up_cnt;
        end
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    // ------------
    // assertions
    // ------------
    chk_gate_a_off: assert property (
        lo_a >= GLITCH_CYCLES + 6 |-> !o_gate_enable_a)
        else $error("gate a on after channel a off");
    chk_gate_b_off: assert property (
        lo_b >= GLITCH_CYCLES + 6 |-> !o_gate_enable_b)
        else $error("gate b on after channel b off");
    chk_feedback_early: assert property (
        $rose(o_cutoff_feedback_output) && up_cnt == 15 |->
        lo_a > GLITCH_CYCLES && lo_b > GLITCH_CYCLES)
        else $error("feedback rose on a short off pulse");
    chk_feedback_late: assert property (
        lo_a >= GLITCH_CYCLES + 8 && lo_b >= GLITCH_CYCLES + 8 |->
        o_cutoff_feedback_output)
        else $error("feedback missing with both channels off");
    chk_feedback_idle: assert property (
        hi_any >= 6 |-> !o_cutoff_feedback_output)
        else $error("feedback on while a channel is on");
    chk_ready_off: assert property (
        lo_a >= GLITCH_CYCLES + 7 || lo_b >= GLITCH_CYCLES + 7 |->
        !o_drive_ready)
        else $error("ready on during cutoff");
    chk_brake_drop: assert property (
        lo_a >= GLITCH_CYCLES + 7 || lo_b >= GLITCH_CYCLES + 7 |->
        !o_brake_release_output)
        else $error("brake release held during cutoff");
    chk_bus_answer: assert property (
        $rose(i_avs_read || i_avs_write) |->
        o_avs_waitrequest ##1 !o_avs_waitrequest)
        else $error("bus answer not after one wait cycle");

    cov_feedback: cover property ($rose(o_cutoff_feedback_output));
    cov_gate_drop: cover property ($fell(o_gate_enable_a));
    cov_ready: cover property ($rose(o_drive_ready));
endmodule

// ===== test/safety_relay_model.sv
// model of the external safety relay unit feeding both channels
// assumes the bench sets contact requests right after a clock edge
`timescale 1ns/1ps

module safety_relay_model (
    // clock
    input  wire logic i_core_clk,
    // contact requests
    input  wire logic i_close_a,
    input  wire logic i_close_b,
    // channel lines
    output logic      o_chan_a,
    output logic      o_chan_b
);
    // a closed contact lets current flow, seen as high
    always_ff @(posedge i_core_clk) begin
        o_chan_a <= i_close_a;
        o_chan_b <= i_close_b;
    end
endmodule

// ===== test/tb.sv
// self-checking bench: cutoff sequence, monitor word, interrupts
// assumes the design package and shortened glitch and mismatch counts
`timescale 1ns/1ps

module tb
    import safe_cutoff_pkg::*;
;
    localparam int GLITCH_CYCLES   = 20;
    localparam int MISMATCH_CYCLES = 100;
    logic        i_core_clk        = 1'b0;
    logic        i_rst             = 1'b1;
    logic        close_a           = 1'b1;
    logic        close_b           = 1'b1;
    logic        i_main_power_on   = 1'b1;
    logic        i_standalone_mode = 1'b0;
    logic [4:0]  i_avs_address     = 5'h00;
    logic        i_avs_read        = 1'b0;
    logic        i_avs_write       = 1'b0;
    logic [31:0] i_avs_writedata   = 32'h0;
    logic        chan_a, chan_b, o_avs_waitrequest, o_irq;
    logic        o_gate_enable_a, o_gate_enable_b, o_drive_ready;
    logic        o_brake_release_output, o_cutoff_feedback_output;
    logic [31:0] o_avs_readdata, rd;
    logic [15:0] bd;
    logic        m_warn = 1'b0;
    logic        m_alarm = 1'b0;
    int          m_st = 2; // 0 blocked, 1 energized, 2 cutoff
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          seed = 32'hcb9c;

    always #25 i_core_clk = ~i_core_clk;

    safety_relay_model safety_relay_model_i (.i_core_clk,
        .i_close_a(close_a), .i_close_b(close_b),
        .o_chan_a(chan_a), .o_chan_b(chan_b));
    safe_torque_cutoff_ctrl #(.GLITCH_CYCLES(GLITCH_CYCLES),
        .MISMATCH_CYCLES(MISMATCH_CYCLES)) safe_torque_cutoff_ctrl_i (
        .i_core_clk, .i_rst,
        .i_safety_off_request_a(chan_a), .i_safety_off_request_b(chan_b),
        .i_main_power_on, .i_standalone_mode, .i_avs_address, .i_avs_read,
        .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest,
        .o_gate_enable_a, .o_gate_enable_b, .o_drive_ready, .o_irq,
        .o_brake_release_output, .o_cutoff_feedback_output);

    // ------------
    // tasks
    // ------------
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_word(string name, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_pin(string name, logic exp, logic got);
        chk_word(name, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic bus(logic wr, logic [4:0] adr, logic [31:0] wd);
        int n;
        n = 0;
        @(posedge i_core_clk);
        i_avs_address   <= adr;
        i_avs_writedata <= wd;
        i_avs_read      <= !wr;
        i_avs_write     <= wr;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 20);
        rd = o_avs_readdata;
        i_avs_read  <= 1'b0;
        i_avs_write <= 1'b0;
        if (n >= 20) begin
            error_cnt++;
            stop_test();
        end
    endtask

    task automatic chk_reg(string name, logic [4:0] adr, logic [31:0] exp);
        bus(1'b0, adr, 32'h0);
        chk_word(name, exp, rd);
    endtask

    task automatic chk_mon();
        chk_reg("monitor", ADDR_MONITOR, exp_mon());
    endtask

    // both channels off long enough to cut, then both back on
    task automatic both_off_on();
        @(posedge i_core_clk);
        close_a <= 1'b0;
        close_b <= 1'b0;
        settle();
        @(posedge i_core_clk);
        close_a <= 1'b1;
        close_b <= 1'b1;
        settle();
    endtask

    // expected monitor word from the model state
    function automatic logic [31:0] exp_mon();
        logic [1:0] code;
        code = (m_st == 0) ? 2'b00 : (m_st == 1) ? 2'b01 : 2'b10;
        return {22'h0, code, 1'b0, close_b, close_a, !close_a && !close_b,
                m_alarm, m_warn, m_st == 0 && close_a && close_b, m_st == 2};
    endfunction

    task automatic settle();
        repeat (GLITCH_CYCLES + 12) @(posedge i_core_clk);
    endtask

    task automatic pulse_a(int len);
        @(posedge i_core_clk);
        close_a <= 1'b0;
        repeat (len) @(posedge i_core_clk);
        close_a <= 1'b1;
        settle();
        chk_mon();
    endtask

    initial begin
        repeat (100000) @(posedge i_core_clk);
        error_cnt++;
        stop_test();
    end

    // ------------
    // main sequence
    // ------------
    initial begin
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        settle();
        chk_reg("brake_delay", ADDR_BRAKE_DELAY, {16'h0, BRAKE_DELAY_RST});
        chk_reg("irq_mask", ADDR_IRQ_MASK, {29'h0, IRQ_MASK_RST});
        chk_reg("cmd", ADDR_CMD, 32'h0);
        bus(1'b1, 5'h18, 32'hffffffff);
        chk_reg("unmapped", 5'h18, 32'h0);
        bd = 16'($random(seed));
        bus(1'b1, ADDR_BRAKE_DELAY, {16'h0, bd});
        chk_reg("brake_delay", ADDR_BRAKE_DELAY, {16'h0, bd});
        bus(1'b1, ADDR_IRQ_STATUS, 32'h7);
        bus(1'b1, ADDR_IRQ_MASK, 32'h7);
        chk_mon();
        chk_pin("irq", 1'b0, o_irq);
        $display("test reset done");
        bus(1'b1, ADDR_CMD, {24'h0, CMD_DEENERGIZE});
        m_st = 0;
        settle();
        chk_mon();
        chk_pin("ready", 1'b1, o_drive_ready);
        bus(1'b1, ADDR_CMD, {24'h0, CMD_ENERGIZE});
        bus(1'b1, ADDR_CTRL, 32'h1);
        m_st = 1;
        settle();
        chk_mon();
        chk_pin("gate_b", 1'b1, o_gate_enable_b);
        $display("test energize done");
        pulse_a(GLITCH_CYCLES);
        pulse_a(1 + int'($unsigned($random(seed)) % GLITCH_CYCLES));
        $display("test glitch done");
        @(posedge i_core_clk);
        close_a <= 1'b0;
        m_st = 2;
        m_warn = 1'b1;
        settle();
        chk_mon();
        chk_pin("gate_a", 1'b0, o_gate_enable_a);
        chk_pin("brake", 1'b0, o_brake_release_output);
        chk_reg("irq_status", ADDR_IRQ_STATUS, 32'h3);
        chk_pin("irq", 1'b1, o_irq);
        bus(1'b1, ADDR_IRQ_MASK, 32'h0);
        @(posedge i_core_clk);
        chk_pin("irq_masked", 1'b0, o_irq);
        repeat (MISMATCH_CYCLES + 20) @(posedge i_core_clk);
        m_alarm = 1'b1;
        chk_mon();
        chk_reg("irq_status", ADDR_IRQ_STATUS, 32'h7);
        $display("test cutoff done");
        @(posedge i_core_clk);
        close_b <= 1'b0;
        settle();
        chk_mon();
        bus(1'b1, ADDR_CMD, {24'h0, CMD_ENERGIZE});
        @(posedge i_core_clk);
        close_a <= 1'b1;
        close_b <= 1'b1;
        settle();
        chk_mon();
        bus(1'b1, ADDR_CMD, {24'h0, CMD_DEENERGIZE});
        m_st = 0;
        settle();
        chk_mon();
        bus(1'b1, ADDR_CTRL, 32'h2);
        bus(1'b1, ADDR_IRQ_STATUS, 32'h7);
        bus(1'b1, ADDR_IRQ_MASK, 32'h7);
        m_warn = 1'b0;
        m_alarm = 1'b0;
        chk_mon();
        chk_reg("irq_status", ADDR_IRQ_STATUS, 32'h0);
        chk_pin("irq", 1'b0, o_irq);
        $display("test release done");
        i_standalone_mode <= 1'b1;
        bus(1'b1, ADDR_CMD, {24'h0, CMD_ENERGIZE});
        m_st = 2;
        m_warn = 1'b1;
        both_off_on();
        chk_mon();
        i_standalone_mode <= 1'b0;
        @(posedge i_core_clk);
        i_standalone_mode <= 1'b1;
        m_st = 0;
        settle();
        chk_mon();
        i_standalone_mode <= 1'b0;
        i_main_power_on   <= 1'b0;
        m_st = 2;
        both_off_on();
        chk_mon();
        bus(1'b1, ADDR_CMD, {24'h0, CMD_DEENERGIZE});
        m_st = 0;
        settle();
        chk_mon();
        $display("test standalone and power done");
        stop_test();
    end
endmodule

bind safe_torque_cutoff_ctrl safe_cutoff_chk #(
    .GLITCH_CYCLES(GLITCH_CYCLES), .MISMATCH_CYCLES(MISMATCH_CYCLES)
) safe_cutoff_chk_i (.i_core_clk, .i_rst, .i_safety_off_request_a,
    .i_safety_off_request_b, .i_avs_read, .i_avs_write, .o_avs_waitrequest,
    .o_gate_enable_a, .o_gate_enable_b, .o_drive_ready,
    .o_brake_release_output, .o_cutoff_feedback_output);
